// ==== verilog/rx_pcs_lane_align_status.sv ====
// Receive PCS lane alignment status: lane markers, alignment, BIP8,
// high error rate, code violations and test pattern mismatches, with a
// Wishbone register file and one level interrupt.
// Assumes all datapath inputs come from logic on clk_i.
//
// Overview of operation
// - four bad markers in a row hold lane fault
// - malformed lane marker pulses one cycle
// - misalignment pulses one metaframe after bad marker
// - no misalignment before all lanes seen good
// - alignment error high while alignment failed or lost
// - per-lane BIP8 failure pulses one cycle
// - aligned high only when every lane deskewed
// - high error rate while BER above threshold
// - status equals aligned and not high BER
// - two-bit increment counts decode error blocks
// - qualifier marks valid code violation increment
// - eight-bit test mismatch increment while enabled
// - qualifier marks valid test mismatch increment
`timescale 1ns/10ps
`default_nettype none
`include "rx_align_defs.svh"

module rx_pcs_lane_align_status #(
    parameter int LANES = `RXA_NUM_LANES,
    parameter int MF_CYCLES = `RXA_METAFRAME_CYCLES,
    parameter int BER_WINDOW = `RXA_BER_WINDOW_CYCLES,
    parameter int BER_THRESHOLD = `RXA_BER_THRESHOLD
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [`RXA_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    // Lane marker and BIP8 checks per lane
    input wire logic [LANES-1:0] marker_seen_i,
    input wire logic [LANES-1:0] marker_good_i,
    input wire logic [LANES-1:0] bip_fail_i,
    input wire logic deskew_ok_i,
    input wire logic [LANES-1:0] sync_hdr_check_i,
    input wire logic [LANES-1:0] sync_hdr_bad_i,
    // Decoded blocks and test pattern comparator
    input wire logic [1:0] blk_valid_i,
    input wire logic [1:0] blk_bad_i,
    input wire logic tp_check_i,
    input wire logic [7:0] tp_byte_miss_i,
    // Status toward statistics logic
    output logic [LANES-1:0] lane_marker_repeat_fault_o,
    output logic [LANES-1:0] lane_marker_word_fault_o,
    output logic misaligned_o,
    output logic aligned_err_o,
    output logic [LANES-1:0] bip_err_o,
    output logic aligned_o,
    output logic high_error_rate_flag_o,
    output logic rx_status_o,
    output logic [1:0] bad_code_o,
    output logic bad_code_valid_o,
    output logic [7:0] test_err_o,
    output logic test_err_valid_o
);

    localparam int MF_AW = $clog2(MF_CYCLES);
    localparam int BER_CW = $clog2(BER_WINDOW + 1);
    localparam int BAD_CW = $clog2(BER_THRESHOLD + 1);

    logic [LANES-1:0] seen_once;
    logic [LANES-1:0] bad_marker;
    logic all_seen;
    logic next_aligned;

    // Per-lane marker supervision.
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        lane_marker_tracker #(
            .REPEAT_LIMIT(`RXA_REPEAT_LIMIT)
        ) u_tracker (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .marker_seen_i(marker_seen_i[g]),
            .marker_good_i(marker_good_i[g]),
            .word_fault_o(lane_marker_word_fault_o[g]),
            .repeat_fault_o(lane_marker_repeat_fault_o[g]),
            .seen_once_o(seen_once[g]),
            .bad_marker_o(bad_marker[g])
        );
    end

    assign all_seen = &seen_once;

    // The misalignment report is delayed by a whole metaframe through a ring
    // of single-bit entries, so back-to-back errors stay back-to-back. The
    // ring is not cleared at reset; the primed flag masks stale entries.
    logic mf_ring [MF_CYCLES];
    logic [MF_AW-1:0] mf_ptr;
    logic mf_primed;
    logic mf_push;

    assign mf_push = all_seen & (|bad_marker);

    always_ff @(posedge clk_i) begin
        mf_ring[mf_ptr] <= mf_push;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mf_ptr <= '0;
            mf_primed <= 1'b0;
        end else begin
            if (mf_ptr == MF_AW'(MF_CYCLES - 1)) begin
                mf_ptr <= '0;
                mf_primed <= 1'b1;
            end else begin
                mf_ptr <= mf_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            misaligned_o <= 1'b0;
        end else begin
            misaligned_o <= mf_primed & mf_ring[mf_ptr];
        end
    end

    // Alignment holds only while every lane has locked and none is in
    // repeated fault and the deskew logic reports its lanes lined up.
    assign next_aligned = all_seen & ~(|lane_marker_repeat_fault_o) & deskew_ok_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aligned_o <= 1'b0;
            aligned_err_o <= 1'b0;
        end else begin
            aligned_o <= next_aligned;
            aligned_err_o <= all_seen & ~next_aligned;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bip_err_o <= '0;
        end else begin
            bip_err_o <= bip_fail_i;
        end
    end

    // Bit error rate monitor over a fixed window of sync header checks.
    logic [BER_CW-1:0] ber_timer;
    logic [BAD_CW-1:0] ber_bad;
    logic [BAD_CW-1:0] next_ber_bad;
    logic [2:0] hdr_bad_now;
    logic [BAD_CW+2:0] ber_sum;
    logic next_high_ber;

    // The sum is kept wider than the count so a saturated count plus a
    // burst of bad headers cannot wrap below the threshold.
    always_comb begin
        hdr_bad_now = 3'h0;
        for (int k = 0; k < LANES; k++) begin
            hdr_bad_now = hdr_bad_now + 3'(sync_hdr_check_i[k] & sync_hdr_bad_i[k]);
        end
        ber_sum = {3'h0, ber_bad} + {BAD_CW'(0), hdr_bad_now};
        if (ber_sum >= (BAD_CW+3)'(BER_THRESHOLD)) begin
            next_ber_bad = BAD_CW'(BER_THRESHOLD);
            next_high_ber = 1'b1;
        end else begin
            next_ber_bad = BAD_CW'(ber_sum);
            next_high_ber = high_error_rate_flag_o & (ber_timer != BER_CW'(BER_WINDOW - 1));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ber_timer <= '0;
            ber_bad <= '0;
            high_error_rate_flag_o <= 1'b0;
        end else begin
            high_error_rate_flag_o <= next_high_ber;
            if (ber_timer == BER_CW'(BER_WINDOW - 1)) begin
                ber_timer <= '0;
                ber_bad <= '0;
            end else begin
                ber_timer <= ber_timer + 1'b1;
                ber_bad <= next_ber_bad;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_status_o <= 1'b0;
        end else begin
            rx_status_o <= next_aligned & ~next_high_ber;
        end
    end

    // Receive decode state, stepped once per decoded block; up to two
    // blocks arrive per cycle, so the increment is two bits wide.
    rx_align_pkg::dec_state_e dec_state;
    rx_align_pkg::dec_state_e next_dec_state;
    logic [1:0] next_bad_code;
    logic link_up;

    assign link_up = next_aligned & ~high_error_rate_flag_o;

    always_comb begin
        next_dec_state = dec_state;
        next_bad_code = 2'h0;
        for (int k = 0; k < 2; k++) begin
            if (blk_valid_i[k]) begin
                case (next_dec_state)
                    rx_align_pkg::DEC_INIT: begin
                        if (link_up & ~blk_bad_i[k]) begin
                            next_dec_state = rx_align_pkg::DEC_RUN;
                        end
                    end
                    rx_align_pkg::DEC_RUN, rx_align_pkg::DEC_ERR: begin
                        if (blk_bad_i[k]) begin
                            next_dec_state = rx_align_pkg::DEC_ERR;
                            next_bad_code = next_bad_code + 2'h1;
                        end else begin
                            next_dec_state = rx_align_pkg::DEC_RUN;
                        end
                    end
                    default: begin
                        next_dec_state = rx_align_pkg::DEC_INIT;
                    end
                endcase
            end
        end
        if (!link_up) begin
            next_dec_state = rx_align_pkg::DEC_INIT;
            next_bad_code = 2'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_state <= rx_align_pkg::DEC_INIT;
            bad_code_o <= 2'h0;
            bad_code_valid_o <= 1'b0;
        end else begin
            dec_state <= next_dec_state;
            bad_code_o <= next_bad_code;
            bad_code_valid_o <= |blk_valid_i;
        end
    end

    // Test pattern mismatch count, one per mismatching byte lane.
    logic test_pattern_en;
    logic [7:0] next_test_err;

    always_comb begin
        next_test_err = 8'h00;
        for (int k = 0; k < 8; k++) begin
            next_test_err = next_test_err + 8'(tp_byte_miss_i[k]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_err_o <= 8'h00;
            test_err_valid_o <= 1'b0;
        end else begin
            test_err_valid_o <= test_pattern_en & tp_check_i;
            if (test_pattern_en & tp_check_i) begin
                test_err_o <= next_test_err;
            end else begin
                test_err_o <= 8'h00;
            end
        end
    end

    // Event capture; a hardware set in the same cycle as a clear wins.
    logic [`RXA_EV_W-1:0] ev_status;
    logic [`RXA_EV_W-1:0] ev_mask;
    logic [`RXA_EV_W-1:0] ev_now;
    logic repeat_any_d;
    logic align_err_d;
    logic high_ber_d;
    logic bus_req;
    logic bus_wr;

    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign bus_wr = bus_req & we_i & sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            repeat_any_d <= 1'b0;
            align_err_d <= 1'b0;
            high_ber_d <= 1'b0;
        end else begin
            repeat_any_d <= |lane_marker_repeat_fault_o;
            align_err_d <= aligned_err_o;
            high_ber_d <= high_error_rate_flag_o;
        end
    end

    always_comb begin
        ev_now = '0;
        ev_now[`RXA_EV_MISALIGN] = misaligned_o;
        ev_now[`RXA_EV_WORD_FAULT] = |lane_marker_word_fault_o;
        ev_now[`RXA_EV_BIP] = |bip_err_o;
        ev_now[`RXA_EV_REPEAT] = (|lane_marker_repeat_fault_o) & ~repeat_any_d;
        ev_now[`RXA_EV_ALIGN_ERR] = aligned_err_o & ~align_err_d;
        ev_now[`RXA_EV_HIGH_BER] = high_error_rate_flag_o & ~high_ber_d;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_status <= `RXA_STATUS_RST;
        end else if (bus_wr && adr_i == `RXA_STATUS_OFS) begin
            ev_status <= (ev_status & ~dat_i[`RXA_EV_W-1:0]) | ev_now;
        end else begin
            ev_status <= ev_status | ev_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_mask <= `RXA_MASK_RST;
            test_pattern_en <= `RXA_CTRL_RST;
        end else if (bus_wr) begin
            if (adr_i == `RXA_MASK_OFS) begin
                ev_mask <= dat_i[`RXA_EV_W-1:0];
            end
            if (adr_i == `RXA_CTRL_OFS) begin
                test_pattern_en <= dat_i[`RXA_CTRL_TEST_PATTERN];
            end
        end
    end

    assign irq_o = |(ev_status & ev_mask);

    // Wishbone answer one cycle after the request; unmapped addresses are
    // acknowledged and read as zero so a stray access never hangs the bus.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req;
            dat_o <= 32'h00000000;
            if (bus_req && !we_i) begin
                case (adr_i)
                    `RXA_STATUS_OFS: dat_o[`RXA_EV_W-1:0] <= ev_status;
                    `RXA_MASK_OFS: dat_o[`RXA_EV_W-1:0] <= ev_mask;
                    `RXA_CTRL_OFS: dat_o[`RXA_CTRL_TEST_PATTERN] <= test_pattern_en;
                    `RXA_LEVELS_OFS: begin
                        dat_o[`RXA_LVL_ALIGNED] <= aligned_o;
                        dat_o[`RXA_LVL_ALIGN_ERR] <= aligned_err_o;
                        dat_o[`RXA_LVL_HIGH_BER] <= high_error_rate_flag_o;
                        dat_o[`RXA_LVL_STATUS] <= rx_status_o;
                        dat_o[`RXA_LVL_REPEAT_LSB +: LANES] <= lane_marker_repeat_fault_o;
                    end
                    default: dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ==== verilog/rx_align_defs.svh ====
// Constants for the receive lane alignment status block: register map,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef RX_ALIGN_DEFS_SVH
`define RX_ALIGN_DEFS_SVH

`define RXA_NUM_LANES 4
`define RXA_ADR_W 4

`define RXA_STATUS_OFS 4'h0
`define RXA_MASK_OFS 4'h4
`define RXA_CTRL_OFS 4'h8
`define RXA_LEVELS_OFS 4'hC

`define RXA_EV_MISALIGN 0
`define RXA_EV_WORD_FAULT 1
`define RXA_EV_BIP 2
`define RXA_EV_REPEAT 3
`define RXA_EV_ALIGN_ERR 4
`define RXA_EV_HIGH_BER 5
`define RXA_EV_W 6

`define RXA_CTRL_TEST_PATTERN 0

`define RXA_LVL_ALIGNED 0
`define RXA_LVL_ALIGN_ERR 1
`define RXA_LVL_HIGH_BER 2
`define RXA_LVL_STATUS 3
`define RXA_LVL_REPEAT_LSB 4

`define RXA_STATUS_RST 6'h00
`define RXA_MASK_RST 6'h00
`define RXA_CTRL_RST 1'h0

`define RXA_CLK_MHZ 20
`define RXA_BER_WINDOW_US 125
`define RXA_BER_WINDOW_CYCLES (`RXA_BER_WINDOW_US * `RXA_CLK_MHZ)
`define RXA_BER_THRESHOLD 97
`define RXA_METAFRAME_CYCLES 16384
`define RXA_REPEAT_LIMIT 4

`endif

// ==== verilog/rx_align_pkg.sv ====
// Types shared by the receive lane alignment status block.
// Assumes nothing of its surroundings.
package rx_align_pkg;

    typedef enum logic [1:0] {
        DEC_INIT,
        DEC_RUN,
        DEC_ERR
    } dec_state_e;

endpackage

// ==== verilog/lane_marker_tracker.sv ====
// One lane's marker supervisor: malformed word pulse, repeated fault
// level and a sticky flag once a good marker has been seen.
// Assumes marker strobes come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "rx_align_defs.svh"

module lane_marker_tracker #(
    parameter int REPEAT_LIMIT = `RXA_REPEAT_LIMIT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Marker slot of this lane
    input wire logic marker_seen_i,
    input wire logic marker_good_i,
    // Lane state
    output logic word_fault_o,
    output logic repeat_fault_o,
    output logic seen_once_o,
    output logic bad_marker_o
);

    logic [2:0] bad_run;
    logic bad_now;

    assign bad_now = marker_seen_i & ~marker_good_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_fault_o <= 1'b0;
            bad_marker_o <= 1'b0;
        end else begin
            word_fault_o <= bad_now;
            bad_marker_o <= bad_now;
        end
    end

    // A good marker ends the fault condition and restarts the run.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bad_run <= 3'h0;
            repeat_fault_o <= 1'b0;
        end else if (marker_seen_i) begin
            if (marker_good_i) begin
                bad_run <= 3'h0;
                repeat_fault_o <= 1'b0;
            end else begin
                if (bad_run != 3'(REPEAT_LIMIT)) begin
                    bad_run <= bad_run + 3'h1;
                end
                if (bad_run == 3'(REPEAT_LIMIT - 1)) begin
                    repeat_fault_o <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_once_o <= 1'b0;
        end else if (marker_seen_i & marker_good_i) begin
            seen_once_o <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// ==== bench/rx_align_monitor.sv ====
// Checker for the receive lane alignment status block, bound to its top.
// Assumes datapath inputs are held low while reset is asserted.
`timescale 1ns/10ps
`default_nettype none
module rx_align_monitor #(
    parameter int LANES = 4,
    parameter int MF_CYCLES = 16
) (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // Lane and block inputs
    input wire logic [LANES-1:0] marker_seen_i,
    input wire logic [LANES-1:0] marker_good_i,
    input wire logic [LANES-1:0] bip_fail_i,
    input wire logic [1:0] blk_valid_i,
    input wire logic tp_check_i,
    input wire logic [7:0] tp_byte_miss_i,
    // Status outputs
    input wire logic [LANES-1:0] lane_marker_repeat_fault_o,
    input wire logic [LANES-1:0] lane_marker_word_fault_o,
    input wire logic misaligned_o,
    input wire logic aligned_err_o,
    input wire logic [LANES-1:0] bip_err_o,
    input wire logic aligned_o,
    input wire logic high_error_rate_flag_o,
    input wire logic rx_status_o,
    input wire logic bad_code_valid_o,
    input wire logic [7:0] test_err_o,
    input wire logic test_err_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence bus_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence ack_once;
        ack_o ##1 !ack_o;
    endsequence
    a_bus_answer: assert property (bus_req |=> ack_once)
        else $error("bus request not answered by a single ack");
    a_word_fault_pulse: assert property (
        1 |=> lane_marker_word_fault_o == $past(marker_seen_i & ~marker_good_i))
        else $error("word fault does not follow malformed marker");
    a_repeat_rise_cause: assert property (
        (lane_marker_repeat_fault_o & ~$past(lane_marker_repeat_fault_o)
        & ~$past(marker_seen_i & ~marker_good_i)) == '0) else $error("repeat fault rose without bad marker");
    a_repeat_good_clear: assert property (
        (lane_marker_repeat_fault_o & $past(marker_seen_i & marker_good_i)) == '0)
        else $error("repeat fault held across good marker");
    a_misalign_cause: assert property (
        misaligned_o |-> $past(|(marker_seen_i & ~marker_good_i), MF_CYCLES + 2))
        else $error("misalignment pulse without bad marker one metaframe earlier");
    a_bip_lane_pulse: assert property (1 |=> bip_err_o == $past(bip_fail_i))
        else $error("parity error output does not follow failed check");
    a_align_exclusive: assert property (aligned_o |-> !aligned_err_o)
        else $error("aligned and alignment error both high");
    a_status_exact: assert property (
        rx_status_o == (aligned_o && !high_error_rate_flag_o)) else $error("status mismatch");
    a_code_valid_delay: assert property (
        1 |=> bad_code_valid_o == $past(|blk_valid_i)) else $error("code qualifier wrong");
    a_test_err_count: assert property (
        test_err_valid_o |-> $past(tp_check_i) && test_err_o == 8'($past($countones(tp_byte_miss_i))))
        else $error("test mismatch increment wrong");
    a_test_err_idle: assert property (!test_err_valid_o |-> test_err_o == 8'h00)
        else $error("test mismatch increment outside qualifier");
endmodule
bind rx_pcs_lane_align_status rx_align_monitor #(.LANES(LANES), .MF_CYCLES(MF_CYCLES))
    i_rx_align_monitor (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .marker_seen_i(marker_seen_i), .marker_good_i(marker_good_i), .bip_fail_i(bip_fail_i),
    .blk_valid_i(blk_valid_i), .tp_check_i(tp_check_i), .tp_byte_miss_i(tp_byte_miss_i),
    .lane_marker_repeat_fault_o(lane_marker_repeat_fault_o),
    .lane_marker_word_fault_o(lane_marker_word_fault_o), .misaligned_o(misaligned_o),
    .aligned_err_o(aligned_err_o), .bip_err_o(bip_err_o), .aligned_o(aligned_o),
    .high_error_rate_flag_o(high_error_rate_flag_o), .rx_status_o(rx_status_o),
    .bad_code_valid_o(bad_code_valid_o), .test_err_o(test_err_o),
    .test_err_valid_o(test_err_valid_o));
`default_nettype wire

// ==== bench/rx_stats_model.sv ====
// Statistics counters that sit behind the status outputs.
// Assumes the same clock and reset as the status block.
`timescale 1ns/10ps
`default_nettype none
module rx_stats_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Increments and pulses
    input wire logic [1:0] bad_code_o,
    input wire logic bad_code_valid_o,
    input wire logic [7:0] test_err_o,
    input wire logic test_err_valid_o,
    input wire logic misaligned_o,
    // Totals
    output logic [15:0] code_total_o,
    output logic [15:0] test_total_o,
    output logic [15:0] misalign_total_o
);
    // Increments are taken only under their qualifiers, never otherwise.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_total_o <= 16'h0000;
            test_total_o <= 16'h0000;
            misalign_total_o <= 16'h0000;
        end else begin
            if (bad_code_valid_o) code_total_o <= code_total_o + 16'(bad_code_o);
            if (test_err_valid_o) test_total_o <= test_total_o + 16'(test_err_o);
            if (misaligned_o) misalign_total_o <= misalign_total_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== bench/rx_pcs_lane_align_status_tb.sv ====
// Self-checking bench for the lane alignment status block.
// Assumes small metaframe and error-rate window counts for speed.
`timescale 1ns/10ps
`default_nettype none
`include "rx_align_defs.svh"
module rx_pcs_lane_align_status_tb;
    localparam int MF = 16;
    localparam int WIN = 64;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, deskew_ok_i = 1'b0;
    logic tp_check_i = 1'b0, ack_o, irq_o, misaligned_o, aligned_err_o, aligned_o, hi_ber;
    logic rx_status_o, bad_code_valid_o, test_err_valid_o;
    logic [3:0] adr_i = 4'h0, marker_seen_i = 4'h0, marker_good_i = 4'h0, bip_fail_i = 4'h0;
    logic [3:0] hdr_chk = 4'h0, hdr_bad = 4'h0, rep_flt, word_flt, bip_err_o;
    logic [1:0] blk_valid_i = 2'h0, blk_bad_i = 2'h0, bad_code_o;
    logic [7:0] tp_byte_miss_i = 8'h00, test_err_o;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [15:0] code_total, test_total, misalign_total, snap;
    int num_errors = 0, comparisons = 0;
    always #25 clk_i = ~clk_i;
    rx_pcs_lane_align_status #(.MF_CYCLES(MF), .BER_WINDOW(WIN), .BER_THRESHOLD(4)) i_rx_pcs_lane_align_status (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
        .marker_seen_i(marker_seen_i), .marker_good_i(marker_good_i), .bip_fail_i(bip_fail_i),
        .deskew_ok_i(deskew_ok_i), .sync_hdr_check_i(hdr_chk), .sync_hdr_bad_i(hdr_bad),
        .blk_valid_i(blk_valid_i), .blk_bad_i(blk_bad_i), .tp_check_i(tp_check_i),
        .tp_byte_miss_i(tp_byte_miss_i), .lane_marker_repeat_fault_o(rep_flt),
        .lane_marker_word_fault_o(word_flt), .misaligned_o(misaligned_o),
        .aligned_err_o(aligned_err_o), .bip_err_o(bip_err_o), .aligned_o(aligned_o),
        .high_error_rate_flag_o(hi_ber), .rx_status_o(rx_status_o), .bad_code_o(bad_code_o),
        .bad_code_valid_o(bad_code_valid_o), .test_err_o(test_err_o),
        .test_err_valid_o(test_err_valid_o));
    rx_stats_model i_rx_stats_model (.clk_i(clk_i), .rst_i(rst_i), .bad_code_o(bad_code_o),
        .bad_code_valid_o(bad_code_valid_o), .test_err_o(test_err_o),
        .test_err_valid_o(test_err_valid_o), .misaligned_o(misaligned_o),
        .code_total_o(code_total), .test_total_o(test_total), .misalign_total_o(misalign_total));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Classic cycle: request held until ack is sampled, then released.
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        if (n >= 20) num_errors++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic levels(input logic [3:0] exp);
        chk({aligned_o, aligned_err_o, hi_ber, rx_status_o}, exp);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        step(5000);
        num_errors++;
        give_verdict();
    end
    initial begin
        step(5);
        rst_i <= 1'b0;
        step(1);
        chk({rep_flt, word_flt, misaligned_o, bip_err_o, bad_code_o, test_err_o}, 0);
        levels(4'h0);
        wb(1'b0, `RXA_STATUS_OFS, 0);
        chk(rd, 0);
        wb(1'b0, `RXA_MASK_OFS, 0);
        chk(rd, 0);
        wb(1'b0, 4'h2, 0);
        chk(rd, 0);
        step(MF + 4);
        marker_seen_i <= 4'h2;
        step(1);
        marker_seen_i <= 4'h0;
        step(1);
        chk(word_flt, 4'h2);
        step(1);
        chk(word_flt, 4'h0);
        step(MF + 4);
        chk(misalign_total, 0);
        $display("marker word fault test done");
        marker_seen_i <= 4'hF;
        marker_good_i <= 4'hF;
        deskew_ok_i <= 1'b1;
        step(1);
        marker_seen_i <= 4'h0;
        step(3);
        levels(4'b1001);
        marker_seen_i <= 4'h4;
        marker_good_i <= 4'h0;
        step(4);
        chk(rep_flt, 4'h0);
        marker_seen_i <= 4'h0;
        step(1);
        chk(rep_flt, 4'h4);
        step(2);
        levels(4'b0100);
        wb(1'b0, `RXA_LEVELS_OFS, 0);
        chk(rd, 32'h42);
        step(MF + 4);
        chk(misalign_total, 4);
        marker_seen_i <= 4'h4;
        marker_good_i <= 4'h4;
        step(1);
        marker_seen_i <= 4'h0;
        step(3);
        chk(rep_flt, 4'h0);
        levels(4'b1001);
        $display("repeat fault and alignment test done");
        for (int i = 0; i < 4; i++) begin
            bip_fail_i <= 4'(1 << i);
            step(1);
            bip_fail_i <= 4'h0;
            step(1);
            chk(bip_err_o, 1 << i);
        end
        hdr_chk <= 4'hF;
        hdr_bad <= 4'hF;
        step(8);
        hdr_bad <= 4'h0;
        step(3);
        levels(4'b1010);
        step(2 * WIN + 4);
        levels(4'b1001);
        hdr_chk <= 4'h0;
        $display("parity and error rate test done");
        snap = code_total;
        blk_valid_i <= 2'h3;
        step(1);
        blk_bad_i <= 2'h3;
        step(3);
        blk_valid_i <= 2'h0;
        blk_bad_i <= 2'h0;
        step(4);
        chk(code_total - snap, 6);
        snap = test_total;
        tp_check_i <= 1'b1;
        tp_byte_miss_i <= 8'hFF;
        step(1);
        tp_check_i <= 1'b0;
        step(3);
        chk(test_total - snap, 0);
        wb(1'b1, `RXA_CTRL_OFS, 1);
        tp_check_i <= 1'b1;
        tp_byte_miss_i <= 8'h0F;
        step(1);
        tp_byte_miss_i <= 8'hFF;
        step(1);
        tp_check_i <= 1'b0;
        step(3);
        chk(test_total - snap, 12);
        $display("code violation and test pattern test done");
        wb(1'b0, `RXA_STATUS_OFS, 0);
        chk(rd, 32'h3F);
        chk(irq_o, 0);
        wb(1'b1, `RXA_MASK_OFS, 32'h2);
        step(1);
        chk(irq_o, 1);
        wb(1'b1, `RXA_STATUS_OFS, 32'h3F);
        step(1);
        chk(irq_o, 0);
        wb(1'b1, 4'h2, 32'hFF);
        wb(1'b0, 4'h2, 0);
        chk(rd, 0);
        wb(1'b0, `RXA_MASK_OFS, 0);
        chk(rd, 32'h2);
        $display("register and interrupt test done");
        give_verdict();
    end
endmodule
`default_nettype wire
